// *** failsafe_regs_pkg.sv ***
/*
 * Shared constants and carriers for the fail-safe register bank.
 * Assumes a serial-control front end that turns each host frame into one
 * register request on the system clock.
 */
package failsafe_regs_pkg;

  // Register indices on the request port.
  localparam logic [2:0] IDX_SCALING = 3'h0;
  localparam logic [2:0] IDX_WINDOW  = 3'h1;
  localparam logic [2:0] IDX_SEED    = 3'h2;
  localparam logic [2:0] IDX_ANSWER  = 3'h3;
  localparam logic [2:0] IDX_STATUS  = 3'h4;

  // Scaling register field layout.
  localparam int OFFSET_CODE_LSB = 10;
  localparam int OFFSET_CODE_W   = 6;
  localparam int POLARITY_BIT    = 9;

  // Window register field layout.
  localparam int WINDOW_LSB   = 12;
  localparam int DUTY_LSB     = 8;
  localparam int DUTY_W       = 3;
  localparam int RECOVERY_LSB = 0;

  // Reset values and write masks.
  localparam logic [15:0] SCALING_RST = 16'h0000;
  localparam logic [15:0] WINDOW_RST  = 16'h320b;
  localparam logic [15:0] SEED_RST    = 16'h5ab2;
  localparam logic [15:0] ANSWER_RST  = 16'h0000;
  localparam logic [15:0] STATUS_RST  = 16'h0000;
  localparam logic [15:0] WINDOW_MASK = 16'hf70f;
  localparam logic [15:0] SCALING_MASK = 16'hfe00;

  // Fixed refresh word of the simple watchdog.
  localparam logic [15:0] SIMPLE_ANSWER = 16'h5ab2;

  // One offset step is 6.25 mV, kept as hundredths of a millivolt.
  localparam logic [16:0] OFFSET_STEP_CMV = 17'h00271;

  // Status bit of the core supply overvoltage flag.
  localparam int CORE_OV_BIT = 15;

  // One register request from the serial front end.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [2:0]  idx;
    logic [15:0] wdata;
  } reg_req_s;

endpackage : failsafe_regs_pkg

// *** sticky_flag_bank.sv ***
/*
 * Sixteen sticky fault flags with write-one-to-clear.
 * Assumes fault inputs are synchronous level indications.
 */
`timescale 1ns/10ps
module sticky_flag_bank
  import failsafe_regs_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Fault levels and host clear mask.
  input  wire logic [15:0] fault_in,
  input  wire logic [15:0] clear_in,
  // Held flags.
  output logic      [15:0] flags_q
);

  logic [15:0] flags_d;

  // A fault in the clearing cycle keeps its flag set.
  for (genvar i = 0; i < 16; i++)
  begin : g_flag
    always_comb
    begin
      flags_d[i] = fault_in[i] | (flags_q[i] & ~clear_in[i]);
    end
  end

  // Flags start clear on power-on reset.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flags_q <= STATUS_RST;
    else
      flags_q <= flags_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_flag_holds: assert property (
    ($rose(flags_q[0]) && !clear_in[0])
      ##1 (!clear_in[0] && !fault_in[0]) [*3] |-> flags_q[0])
    else $error("Flag dropped without a clear.");

  a_clear_acts: assert property (
    (clear_in[0] && !fault_in[0]) |=> !flags_q[0])
    else $error("Written one did not clear the flag.");

endmodule : sticky_flag_bank

// *** failsafe_watchdog_status_regs.sv ***
/*
 * Fail-safe register bank: scaling offset, watchdog window, seed, answer
 * and rail over/undervoltage status.
 * Assumes the serial front end presents one request per cycle at most and
 * samples the read data on the cycle after a read request.
 */
// Function
// - Offset code is an unsigned magnitude in 6.25 mV steps from zero.
// - Polarity zero means negative offset, one positive; reset clears it.
// - Seed register holds sixteen-bit LFSR value, 0x5ab2 after reset.
// - Core monitor overvoltage sets its status flag to one.
// - Status flags read zero until a fault; reset clears them.
// - Flags clear only on reset or host writing one; zero does nothing.
`timescale 1ns/10ps
module failsafe_watchdog_status_regs
  import failsafe_regs_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Register requests from the serial front end.
  input  wire reg_req_s    req,
  output logic      [15:0] rdata_q,
  output logic             rvalid_q,
  // Monitor fault levels, core overvoltage on bit 15.
  input  wire logic [15:0] rail_fault,
  // Watchdog mode select, high for challenger.
  input  wire logic        wdg_challenger_mode,
  // Decoded controls toward the regulators and the watchdog.
  output logic signed [17:0] scaling_offset_cmv_q,
  output logic      [3:0]  wdg_window_period_q,
  output logic      [2:0]  wdg_window_duty_q,
  output logic      [3:0]  wdg_recovery_period_q,
  output logic      [15:0] wdg_expected_answer_q,
  output logic             wdg_answer_written_q,
  output logic             wdg_answer_match_q
);

  ////////////////////////////////////////////////////////////////////////
  // Writable registers.

  logic [15:0] scaling_q, scaling_d;
  logic [15:0] window_q, window_d;
  logic [15:0] wdg_lfsr_seed_q, wdg_lfsr_seed_d;
  logic [15:0] wdg_response_word_q, wdg_response_word_d;
  logic [15:0] status_flags;
  logic [15:0] status_clear;

  // Write decode; reserved bits stay zero.
  always_comb
  begin
    scaling_d           = scaling_q;
    window_d            = window_q;
    wdg_lfsr_seed_d     = wdg_lfsr_seed_q;
    wdg_response_word_d = wdg_response_word_q;
    status_clear        = 16'h0000;
    if (req.wr)
    begin
      unique case (req.idx)
        IDX_SCALING: scaling_d = req.wdata & SCALING_MASK;
        IDX_WINDOW:  window_d = req.wdata & WINDOW_MASK;
        IDX_SEED:    wdg_lfsr_seed_d = req.wdata;
        IDX_ANSWER:  wdg_response_word_d = req.wdata;
        IDX_STATUS:  status_clear = req.wdata;
        default:     ;
      endcase
    end
  end

  // Register the configuration; power-on values load on reset.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scaling_q           <= SCALING_RST;
      window_q            <= WINDOW_RST;
      wdg_lfsr_seed_q     <= SEED_RST;
      wdg_response_word_q <= ANSWER_RST;
    end
    else
    begin
      scaling_q           <= scaling_d;
      window_q            <= window_d;
      wdg_lfsr_seed_q     <= wdg_lfsr_seed_d;
      wdg_response_word_q <= wdg_response_word_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags.

  // Fault levels set flags; host ones clear them.
  sticky_flag_bank sticky_flag_bank_inst (
    .clk      (clk),
    .rst      (rst),
    .fault_in (rail_fault),
    .clear_in (status_clear),
    .flags_q  (status_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read port and decoded outputs.

  logic [15:0]        rdata_d;
  logic [16:0]        offset_mag;
  logic signed [17:0] offset_d;
  logic [15:0]        expected_d;
  logic               written_d;
  logic               match_d;

  // Read mux; an unmapped index reads zero.
  always_comb
  begin
    unique case (req.idx)
      IDX_SCALING: rdata_d = scaling_q;
      IDX_WINDOW:  rdata_d = window_q;
      IDX_SEED:    rdata_d = wdg_lfsr_seed_q;
      IDX_ANSWER:  rdata_d = wdg_response_word_q;
      IDX_STATUS:  rdata_d = status_flags;
      default:     rdata_d = 16'h0000;
    endcase
  end

  // Offset in hundredths of mV, signed by the polarity bit.
  always_comb
  begin
    offset_mag = 17'(scaling_q[OFFSET_CODE_LSB +: OFFSET_CODE_W]
                     * OFFSET_STEP_CMV);
    if (scaling_q[POLARITY_BIT])
      offset_d = $signed({1'b0, offset_mag});
    else
      offset_d = -$signed({1'b0, offset_mag});
  end

  // Expected answer: challenger (4L+6-4)/4 truncates to L, then inverted; simple mode is 0x5ab2.
  always_comb
  begin
    if (wdg_challenger_mode)
      expected_d = ~16'((({2'b00, wdg_lfsr_seed_q} << 2) + 18'h00006
                        - 18'h00004) >> 2);
    else
      expected_d = SIMPLE_ANSWER;
    written_d = req.wr && (req.idx == IDX_ANSWER);
    match_d   = written_d && (req.wdata == expected_d);
  end

  // All outputs come from flops.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q               <= 16'h0000;
      rvalid_q              <= 1'b0;
      scaling_offset_cmv_q  <= 18'sh00000;
      wdg_window_period_q   <= WINDOW_RST[WINDOW_LSB +: 4];
      wdg_window_duty_q     <= WINDOW_RST[DUTY_LSB +: DUTY_W];
      wdg_recovery_period_q <= WINDOW_RST[RECOVERY_LSB +: 4];
      wdg_expected_answer_q <= SIMPLE_ANSWER;
      wdg_answer_written_q  <= 1'b0;
      wdg_answer_match_q    <= 1'b0;
    end
    else
    begin
      rdata_q               <= rdata_d;
      rvalid_q              <= req.rd;
      scaling_offset_cmv_q  <= offset_d;
      wdg_window_period_q   <= window_q[WINDOW_LSB +: 4];
      wdg_window_duty_q     <= window_q[DUTY_LSB +: DUTY_W];
      wdg_recovery_period_q <= window_q[RECOVERY_LSB +: 4];
      wdg_expected_answer_q <= expected_d;
      wdg_answer_written_q  <= written_d;
      wdg_answer_match_q    <= match_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_offset_step: assert property (
    scaling_q[POLARITY_BIT] |=> (scaling_offset_cmv_q ==
      18'sd625 * $signed({12'h000, $past(scaling_q[15:10])})))
    else $error("Offset magnitude is not 6.25 mV per code.");

  a_polarity_sign: assert property (
    (!scaling_q[POLARITY_BIT] && scaling_q[15:10] != 6'h00)
      |=> scaling_offset_cmv_q < 0)
    else $error("Polarity zero did not give a negative offset.");

  a_seed_keeps: assert property (
    !(req.wr && req.idx == IDX_SEED) |=> $stable(wdg_lfsr_seed_q))
    else $error("Seed changed without a write.");

  a_core_ov_set: assert property (
    rail_fault[CORE_OV_BIT] |=> status_flags[CORE_OV_BIT])
    else $error("Core overvoltage flag not set.");

  a_flag_no_cause: assert property (
    $rose(status_flags[CORE_OV_BIT]) |-> $past(rail_fault[CORE_OV_BIT]))
    else $error("Flag rose without a fault.");

  a_zero_write_keeps: assert property (
    (req.wr && req.idx == IDX_STATUS && req.wdata == 16'h0000)
      |=> status_flags == ($past(status_flags) | $past(rail_fault)))
    else $error("Writing zero changed the status.");

  a_sticky_flag: assert property (
    (status_flags[CORE_OV_BIT] && !status_clear[CORE_OV_BIT])
      |=> status_flags[CORE_OV_BIT])
    else $error("Core overvoltage flag did not hold.");

  a_read_latency: assert property (
    (req.rd && req.idx == IDX_SEED && !req.wr)
      |=> rvalid_q && rdata_q == $past(wdg_lfsr_seed_q))
    else $error("Seed read not returned one cycle later.");

endmodule : failsafe_watchdog_status_regs

// *** reg_host_model.sv ***
/*
 * Host-side model that issues register requests to the fail-safe bank.
 * Assumes the bank samples requests on the rising clock edge.
 */
`timescale 1ns/10ps
module reg_host_model
  import failsafe_regs_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  // Request port toward the bank.
  output reg_req_s         req,
  input  wire logic [15:0] rdata_q,
  input  wire logic        rvalid_q
);
  // Idle request; released qualifiers never keep the last value.
  initial req = '{wr: 1'b0, rd: 1'b0, idx: 3'h7, wdata: 16'ha5a5};

  ////////////////////////////////////////////////////////////////////////////
  // Drops the strobe after one sampling edge and scrambles the qualifiers.
  task automatic drop();
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, idx: ~req.idx, wdata: ~req.wdata};
  endtask : drop

  // Writes one word.
  task automatic wr(input logic [2:0] idx, input logic [15:0] d);
    @(negedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
    drop();
  endtask : wr

  // Reads one word; the answer stands in the cycle after the request.
  task automatic rd(input logic [2:0] idx, output logic [15:0] d,
                    output logic ok);
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: req.wdata};
    drop();
    ok = rvalid_q;
    d = rdata_q;
  endtask : rd

  // Refresh word the host owes the watchdog in either mode.
  function automatic logic [15:0] answer(input logic chal,
                                         input logic [15:0] lfsr);
    logic [17:0] t;
    t = (({2'b00, lfsr} << 2) + 18'h6 - 18'h4) >> 2;
    return chal ? ~t[15:0] : 16'h5ab2;
  endfunction : answer
endmodule : reg_host_model

// *** test_failsafe_watchdog_status_regs.sv ***
/*
 * Self-checking bench for the fail-safe register bank.
 * Assumes the host model drives all requests at the falling edge.
 */
`timescale 1ns/10ps
module test_failsafe_watchdog_status_regs
  import failsafe_regs_pkg::*;
;
  logic               clk;
  logic               rst;
  reg_req_s           req;
  logic        [15:0] rdata_q;
  logic               rvalid_q;
  logic        [15:0] rail_fault;
  logic               mode;
  logic signed [17:0] offs;
  logic        [3:0]  per;
  logic        [2:0]  duty;
  logic        [3:0]  rec;
  logic        [15:0] exp_ans;
  logic               written;
  logic               match;
  logic        [15:0] ans;
  logic               hit;
  logic               wseen;
  int                 err_count;
  int                 n_checks;
  logic        [15:0] rst_tab [8] = '{16'h0000, 16'h320b, 16'h5ab2, 16'h0000,
                                      16'h0000, 16'h0000, 16'h0000, 16'h0000};

  failsafe_watchdog_status_regs failsafe_watchdog_status_regs_inst (
    .clk(clk), .rst(rst), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .rail_fault(rail_fault), .wdg_challenger_mode(mode),
    .scaling_offset_cmv_q(offs), .wdg_window_period_q(per),
    .wdg_window_duty_q(duty), .wdg_recovery_period_q(rec),
    .wdg_expected_answer_q(exp_ans), .wdg_answer_written_q(written),
    .wdg_answer_match_q(match));

  reg_host_model reg_host_model_inst (
    .clk(clk), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q));

  ////////////////////////////////////////////////////////////////////////////
  // Clock of 40 ns and a hang limit that counts as a mismatch.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #400000;
    err_count++;
    end_sim();
  end

  // Compares two values and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Reads a register and checks the answer pulse and data.
  task automatic rchk(input logic [2:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    reg_host_model_inst.rd(idx, d, ok);
    chk({31'h0, ok}, 32'h1);
    chk({16'h0, d}, {16'h0, exp});
  endtask : rchk

  // Prints the counts and the verdict.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence of register accesses.
  initial
  begin
    err_count = 0;
    n_checks = 0;
    rst = 1'b1;
    rail_fault = 16'h0000;
    mode = 1'b0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
      rchk(3'(i), rst_tab[i]);
    // Decoded outputs after reset: window fields, zero offset, simple word.
    chk({21'h0, per, duty, rec}, 32'h1ab);
    chk(32'(offs), 32'h0);
    chk({16'h0, exp_ans}, 32'h5ab2);
    reg_host_model_inst.wr(IDX_SCALING, 16'hfdff);
    rchk(IDX_SCALING, 16'hfc00);
    chk(32'(offs), 32'(18'(-63 * 625)));
    reg_host_model_inst.wr(IDX_SCALING, 16'h0600);
    repeat (3) @(negedge clk);
    chk(32'(offs), 32'(625));
    reg_host_model_inst.wr(IDX_WINDOW, 16'hffff);
    rchk(IDX_WINDOW, 16'hf70f);
    chk({21'h0, per, duty, rec}, 32'h7ff);
    reg_host_model_inst.wr(IDX_SEED, 16'h1234);
    rchk(IDX_SEED, 16'h1234);
    // Correct answer must match, the inverted one must not.
    for (int m = 0; m < 2; m++)
    begin
      mode = m[0];
      repeat (3) @(negedge clk);
      ans = reg_host_model_inst.answer(mode, 16'h1234);
      chk({16'h0, exp_ans}, {16'h0, ans});
      for (int b = 0; b < 2; b++)
      begin
        reg_host_model_inst.wr(IDX_ANSWER, b[0] ? ~ans : ans);
        hit = 1'b0;
        wseen = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
          hit |= (match === 1'b1);
          wseen |= (written === 1'b1);
          @(negedge clk);
        end
        chk({31'h0, hit}, {31'h0, ~b[0]});
        chk({31'h0, wseen}, 32'h1);
      end
      rchk(IDX_ANSWER, ~ans);
    end
    // Sticky flags: raise, hold, ignore zero, clear on one.
    for (int b = 0; b < 16; b += 15)
    begin
      rail_fault = 16'h1 << b;
      @(negedge clk);
      rail_fault = 16'h0000;
      rchk(IDX_STATUS, 16'h1 << b);
      reg_host_model_inst.wr(IDX_STATUS, 16'h0000);
      rchk(IDX_STATUS, 16'h1 << b);
      reg_host_model_inst.wr(IDX_STATUS, 16'h1 << b);
      rchk(IDX_STATUS, 16'h0000);
    end
    // A fault in the clearing cycle wins over the host clear.
    rail_fault = 16'h8000;
    reg_host_model_inst.wr(IDX_STATUS, 16'h8000);
    rail_fault = 16'h0000;
    rchk(IDX_STATUS, 16'h8000);
    reg_host_model_inst.wr(IDX_STATUS, 16'h8000);
    rchk(IDX_STATUS, 16'h0000);
    reg_host_model_inst.wr(3'h5, 16'hffff);
    rchk(3'h5, 16'h0000);
    // Reset in mid-run; a fault during reset must not leave a flag.
    rail_fault = 16'h8000;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rail_fault = 16'h0000;
    rchk(IDX_SEED, 16'h5ab2);
    rchk(IDX_SCALING, 16'h0000);
    rchk(IDX_STATUS, 16'h0000);
    rchk(IDX_WINDOW, 16'h320b);
    rchk(IDX_ANSWER, 16'h0000);
    end_sim();
  end
endmodule : test_failsafe_watchdog_status_regs
